/* File: pcgs_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module pcgs_gate (
  input wire logic src_clk,
  input wire logic arst_n,
  input wire logic enable,
  output logic gated_clk
);
  logic en_reg;
  logic en_next;

  // Latch-free equivalent: enable sampled on falling edge, so it only moves while clock low
  always_comb
  begin
    en_next = enable;
  end

  always_ff @(negedge src_clk or negedge arst_n)
  begin
    if (!arst_n)
      en_reg <= 1'b0;
    else
      en_reg <= en_next; // [RL19]
  end

  assign gated_clk = src_clk & en_reg; // [RL19]
endmodule
`default_nettype wire

/* File: pcgs_periph_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pcgs_periph_model (
  input wire logic [4:0] clk_in,
  output logic [7:0] edges [5]
);
  // ----
  // Each peripheral counts the rising clock edges it receives
  // ----
  for (genvar i = 0; i < 5; i++)
  begin : g_cnt
    initial edges[i] = 8'h00;
    always @(posedge clk_in[i]) edges[i] <= edges[i] + 8'h01;
  end
endmodule
`default_nettype wire

/* File: pcgs_pkg.sv */
// What this block does
// RL1: Bit 5 stops serial port clock
// RL2: Bit 4 stops second two-wire clock
// RL3: Bit 3 stops first two-wire clock
// RL4: Bit 1 stops second shift port clock
// RL5: Bit 0 stops first shift port clock
// RL6: Modes 2 and 3 force all clocks off
// RL7: Bit 6 resets to one, stays one
// RL8: Reserved gating and status bits read zero
// RL9: Bit 14 sticky on crystal stable loss
// RL10: Bit 13 sticky on crystal stable gain
// RL11: Bit 12 shows live crystal stable
// RL12: Bit 2 sticky on PLL lock loss
// RL13: Bit 1 sticky on PLL lock gain
// RL14: Bit 0 shows live PLL lock, read-only
// RL15: Exactly four power modes supported
// RL16: PLL event interrupt gated by enable bit
// RL17: Mode 2 sleep stops bus clocks
// RL18: Synchronise and edge-detect status inputs
// RL19: Glitch-free gates change while clock low
package pcgs_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [31:0] PCGS_GATING_OFFSET = 32'h40028014;
  localparam logic [31:0] PCGS_STATUS_OFFSET = 32'h40028018;
  localparam logic [31:0] PCGS_CONTROL_OFFSET = 32'h4002801C;
  localparam logic [15:0] PCGS_GATING_RESET = 16'h0040;
  localparam logic [15:0] PCGS_STATUS_RESET = 16'h0000;
  localparam logic [15:0] PCGS_CONTROL_RESET = 16'h0000;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PCGS_FIRST_SHIFT_BIT = 0;
  localparam int PCGS_SECOND_SHIFT_BIT = 1;
  localparam int PCGS_FIRST_TWOWIRE_BIT = 3;
  localparam int PCGS_SECOND_TWOWIRE_BIT = 4;
  localparam int PCGS_SERIAL_BIT = 5;
  localparam int PCGS_KEEP_ONE_BIT = 6;
  localparam int PCGS_PLL_LIVE_BIT = 0;
  localparam int PCGS_PLL_GAINED_BIT = 1;
  localparam int PCGS_PLL_LOST_BIT = 2;
  localparam int PCGS_XTAL_LIVE_BIT = 12;
  localparam int PCGS_XTAL_GOOD_BIT = 13;
  localparam int PCGS_XTAL_LOST_BIT = 14;
  localparam int PCGS_PLL_IRQ_EN_BIT = 13;
  localparam int PCGS_MODE_LSB = 0;
  localparam logic [15:0] PCGS_GATING_MASK = 16'h007B;
  localparam logic [15:0] PCGS_STATUS_W1C_MASK = 16'h6006;
  localparam int PCGS_NUM_GATES = 5;

  // ----------------------------------------
  // Power modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    PCGS_MODE_ACTIVE = 2'b00,
    PCGS_MODE_CORE_SLEEP = 2'b01,
    PCGS_MODE_BUS_CLOCKS_SLEEP = 2'b10,
    PCGS_MODE_HIBERNATE = 2'b11
  } pcgs_mode_e;

  // ----------------------------------------
  // Register bus carrier
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pcgs_bus_s;

endpackage

/* File: pcgs_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pcgs_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

/* File: pcgs_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pcgs_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire pcgs_pkg::pcgs_bus_s bus,
  output logic [15:0] rdata,
  input wire logic [1:0] power_mode,
  input wire logic core_sleeping,
  input wire logic crystal_stable_in,
  input wire logic pll_locked_in,
  output logic serial_port_gated_clock,
  output logic second_twowire_gated_clock,
  output logic first_twowire_gated_clock,
  output logic second_shift_port_gated_clock,
  output logic first_shift_port_gated_clock,
  output logic bus_clocks_sleep,
  output logic pll_event_irq,
  output logic crystal_event_irq
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic xtal_s;
  logic pll_s;
  logic sleep_s;
  logic [1:0] mode_s;

  pcgs_sync u_sync_xtal (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(crystal_stable_in),
    .sync_out(xtal_s)
  ); // [RL18]
  pcgs_sync u_sync_pll (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(pll_locked_in),
    .sync_out(pll_s)
  ); // [RL18]
  pcgs_sync u_sync_sleep (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(core_sleeping),
    .sync_out(sleep_s)
  );
  pcgs_sync u_sync_m0 (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(power_mode[0]),
    .sync_out(mode_s[0])
  );
  pcgs_sync u_sync_m1 (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(power_mode[1]),
    .sync_out(mode_s[1])
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam int PCGS_N = pcgs_pkg::PCGS_NUM_GATES;

  logic [15:0] gating_reg;
  logic [15:0] gating_next;
  logic [15:0] control_reg;
  logic [15:0] control_next;
  logic xtal_lost_reg;
  logic xtal_lost_next;
  logic xtal_good_reg;
  logic xtal_good_next;
  logic pll_lost_reg;
  logic pll_lost_next;
  logic pll_gained_reg;
  logic pll_gained_next;
  logic xtal_prev_reg;
  logic xtal_prev_next;
  logic pll_prev_reg;
  logic pll_prev_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [PCGS_N-1:0] en_reg;
  logic [PCGS_N-1:0] en_next;
  logic sleep_reg;
  logic sleep_next;
  logic pll_irq_reg;
  logic pll_irq_next;
  logic xtal_irq_reg;
  logic xtal_irq_next;

  pcgs_pkg::pcgs_mode_e mode;
  logic wr_gating;
  logic wr_status;
  logic wr_control;
  logic deep_mode;
  logic [15:0] status_view;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    mode = pcgs_pkg::pcgs_mode_e'(mode_s);
    wr_gating = bus.wr && (bus.addr == pcgs_pkg::PCGS_GATING_OFFSET);
    wr_status = bus.wr && (bus.addr == pcgs_pkg::PCGS_STATUS_OFFSET);
    wr_control = bus.wr && (bus.addr == pcgs_pkg::PCGS_CONTROL_OFFSET);

    // Four modes only; deep modes force clocks off
    case (mode) // [RL15]
      pcgs_pkg::PCGS_MODE_ACTIVE: deep_mode = 1'b0;
      pcgs_pkg::PCGS_MODE_CORE_SLEEP: deep_mode = 1'b0;
      pcgs_pkg::PCGS_MODE_BUS_CLOCKS_SLEEP: deep_mode = 1'b1; // [RL6]
      pcgs_pkg::PCGS_MODE_HIBERNATE: deep_mode = 1'b1; // [RL6]
      default: deep_mode = 1'b1;
    endcase

    gating_next = gating_reg;
    if (wr_gating)
      gating_next = bus.wdata & pcgs_pkg::PCGS_GATING_MASK; // [RL8]
    gating_next[pcgs_pkg::PCGS_KEEP_ONE_BIT] = 1'b1; // [RL7]

    control_next = control_reg;
    if (wr_control)
      control_next = 16'h0000;
    if (wr_control)
      control_next[pcgs_pkg::PCGS_PLL_IRQ_EN_BIT] = bus.wdata[pcgs_pkg::PCGS_PLL_IRQ_EN_BIT];
  end

  // ----------------------------------------
  // Edge detect and event flags
  // ----------------------------------------
  always_comb
  begin
    xtal_prev_next = xtal_s;
    pll_prev_next = pll_s;

    // Set wins over write-one clear
    xtal_lost_next = (xtal_lost_reg && !(wr_status && bus.wdata[pcgs_pkg::PCGS_XTAL_LOST_BIT]))
      || (xtal_prev_reg && !xtal_s); // [RL9]
    xtal_good_next = (xtal_good_reg && !(wr_status && bus.wdata[pcgs_pkg::PCGS_XTAL_GOOD_BIT]))
      || (!xtal_prev_reg && xtal_s); // [RL10]
    pll_lost_next = (pll_lost_reg && !(wr_status && bus.wdata[pcgs_pkg::PCGS_PLL_LOST_BIT]))
      || (pll_prev_reg && !pll_s); // [RL12]
    pll_gained_next = (pll_gained_reg && !(wr_status && bus.wdata[pcgs_pkg::PCGS_PLL_GAINED_BIT]))
      || (!pll_prev_reg && pll_s); // [RL13]
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb
  begin
    status_view = 16'h0000; // [RL8]
    status_view[pcgs_pkg::PCGS_XTAL_LOST_BIT] = xtal_lost_reg;
    status_view[pcgs_pkg::PCGS_XTAL_GOOD_BIT] = xtal_good_reg;
    status_view[pcgs_pkg::PCGS_XTAL_LIVE_BIT] = xtal_s; // [RL11]
    status_view[pcgs_pkg::PCGS_PLL_LOST_BIT] = pll_lost_reg;
    status_view[pcgs_pkg::PCGS_PLL_GAINED_BIT] = pll_gained_reg;
    status_view[pcgs_pkg::PCGS_PLL_LIVE_BIT] = pll_s; // [RL14]

    rdata_next = 16'h0000;
    if (bus.rd)
    begin
      if (bus.addr == pcgs_pkg::PCGS_GATING_OFFSET)
        rdata_next = gating_reg;
      else if (bus.addr == pcgs_pkg::PCGS_STATUS_OFFSET)
        rdata_next = status_view;
      else if (bus.addr == pcgs_pkg::PCGS_CONTROL_OFFSET)
        rdata_next = control_reg;
      else
        rdata_next = 16'h0000;
    end
  end

  // ----------------------------------------
  // Gate enables and output levels
  // ----------------------------------------
  always_comb
  begin
    // Gate enables: gating bit one means clock off, enable one means clock runs
    en_next[4] = !gating_reg[pcgs_pkg::PCGS_SERIAL_BIT] && !deep_mode; // [RL1]
    en_next[3] = !gating_reg[pcgs_pkg::PCGS_SECOND_TWOWIRE_BIT] && !deep_mode; // [RL2]
    en_next[2] = !gating_reg[pcgs_pkg::PCGS_FIRST_TWOWIRE_BIT] && !deep_mode; // [RL3]
    en_next[1] = !gating_reg[pcgs_pkg::PCGS_SECOND_SHIFT_BIT] && !deep_mode; // [RL4]
    en_next[0] = !gating_reg[pcgs_pkg::PCGS_FIRST_SHIFT_BIT] && !deep_mode; // [RL5]

    sleep_next = (mode == pcgs_pkg::PCGS_MODE_BUS_CLOCKS_SLEEP) && sleep_s; // [RL17]

    pll_irq_next = control_reg[pcgs_pkg::PCGS_PLL_IRQ_EN_BIT]
      && (pll_lost_reg || pll_gained_reg); // [RL16]
    xtal_irq_next = xtal_lost_reg || xtal_good_reg;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gating_reg <= pcgs_pkg::PCGS_GATING_RESET; // [RL7]
      control_reg <= pcgs_pkg::PCGS_CONTROL_RESET;
    end
    else
    begin
      gating_reg <= gating_next;
      control_reg <= control_next;
    end
  end

  // ----------------------------------------
  // Event flag registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      xtal_lost_reg <= 1'b0;
      xtal_good_reg <= 1'b0;
      pll_lost_reg <= 1'b0;
      pll_gained_reg <= 1'b0;
      // Previous samples start at the synchronisers' reset level, so no false edge
      xtal_prev_reg <= 1'b0;
      pll_prev_reg <= 1'b0;
    end
    else
    begin
      xtal_lost_reg <= xtal_lost_next;
      xtal_good_reg <= xtal_good_next;
      pll_lost_reg <= pll_lost_next;
      pll_gained_reg <= pll_gained_next;
      xtal_prev_reg <= xtal_prev_next;
      pll_prev_reg <= pll_prev_next;
    end
  end

  // ----------------------------------------
  // Read data register
  // ----------------------------------------
  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_reg <= 16'h0000;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // Enables start off; the first clock after reset loads them for active mode, the synchronisers' reset level, before the power mode is known
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      en_reg <= '0;
      sleep_reg <= 1'b0;
      pll_irq_reg <= 1'b0;
      xtal_irq_reg <= 1'b0;
    end
    else
    begin
      en_reg <= en_next;
      sleep_reg <= sleep_next;
      pll_irq_reg <= pll_irq_next;
      xtal_irq_reg <= xtal_irq_next;
    end
  end

  // ----------------------------------------
  // Clock gates
  // ----------------------------------------
  logic [PCGS_N-1:0] gclk;

  generate
    for (genvar i = 0; i < PCGS_N; i++)
    begin : g_gate
      pcgs_gate u_gate (
        .src_clk(clk),
        .arst_n(arst_n),
        .enable(en_reg[i]),
        .gated_clk(gclk[i])
      ); // [RL19]
    end
  endgenerate

  assign serial_port_gated_clock = gclk[4];
  assign second_twowire_gated_clock = gclk[3];
  assign first_twowire_gated_clock = gclk[2];
  assign second_shift_port_gated_clock = gclk[1];
  assign first_shift_port_gated_clock = gclk[0];
  assign rdata = rdata_reg;
  assign bus_clocks_sleep = sleep_reg;
  assign pll_event_irq = pll_irq_reg;
  assign crystal_event_irq = xtal_irq_reg;

endmodule
`default_nettype wire

/* File: pcgs_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module pcgs_top_bench;
  localparam logic [31:0] GA = pcgs_pkg::PCGS_GATING_OFFSET;
  localparam logic [31:0] ST = pcgs_pkg::PCGS_STATUS_OFFSET;
  localparam logic [31:0] CT = pcgs_pkg::PCGS_CONTROL_OFFSET;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  pcgs_pkg::pcgs_bus_s bus = '0;
  logic [1:0] power_mode = 2'h0;
  logic core_sleeping = 1'b0, crystal_stable_in = 1'b0, pll_locked_in = 1'b0;
  logic [15:0] rdata;
  logic serial_port_gated_clock, second_twowire_gated_clock, first_twowire_gated_clock;
  logic second_shift_port_gated_clock, first_shift_port_gated_clock;
  logic bus_clocks_sleep, pll_event_irq, crystal_event_irq;
  logic [7:0] edges [5];
  int miscompares = 0;
  int comparisons = 0;
  always #4 clk = ~clk;
  pcgs_top u_dut (.*);
  pcgs_periph_model u_periph (
    .clk_in({serial_port_gated_clock, second_twowire_gated_clock, first_twowire_gated_clock,
      second_shift_port_gated_clock, first_shift_port_gated_clock}),
    .edges(edges)
  );
  // ----
  // Bus and compare tasks
  // ----
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 cmp(rdata, exp);
  endtask
  task automatic clocks(input logic [4:0] exp);
    logic [7:0] e0 [5];
    logic [4:0] run;
    repeat (8) @(posedge clk);
    e0 = edges;
    repeat (8) @(posedge clk);
    foreach (run[i]) run[i] = edges[i] != e0[i];
    cmp({11'h000, run}, {11'h000, exp});
  endtask
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    rd(GA, 16'h0040);
    rd(ST, 16'h0000);
    rd(CT, 16'h0000);
    rd(32'h40028020, 16'h0000);
    clocks(5'h1F);
    $display("reset test done");
  endtask
  task automatic t_gates();
    int pos [5] = '{0, 1, 3, 4, 5};
    foreach (pos[i])
    begin
      wr(GA, 16'h0040 | (16'h0001 << pos[i]));
      rd(GA, 16'h0040 | (16'h0001 << pos[i]));
      clocks(5'h1F & ~(5'h01 << i));
    end
    wr(GA, 16'hFFFF);
    rd(GA, 16'h007B);
    clocks(5'h00);
    wr(GA, 16'h0040);
    $display("gating test done");
  endtask
  task automatic t_modes();
    @(posedge clk);
    core_sleeping <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk);
      power_mode <= 2'(m);
      clocks(m < 2 ? 5'h1F : 5'h00);
      cmp({15'h0000, bus_clocks_sleep}, {15'h0000, m == 2});
    end
    @(posedge clk);
    power_mode <= 2'h0;
    core_sleeping <= 1'b0;
    clocks(5'h1F);
    $display("mode test done");
  endtask
  task automatic t_pll();
    wr(CT, 16'h2000);
    pll_locked_in <= 1'b1;
    settle();
    rd(ST, 16'h0003);
    cmp({15'h0000, pll_event_irq}, 16'h0001);
    wr(ST, 16'h0003);
    rd(ST, 16'h0001);
    cmp({15'h0000, pll_event_irq}, 16'h0000);
    @(posedge clk);
    pll_locked_in <= 1'b0;
    settle();
    rd(ST, 16'h0004);
    cmp({15'h0000, pll_event_irq}, 16'h0001);
    wr(CT, 16'h0000);
    rd(ST, 16'h0004);
    cmp({15'h0000, pll_event_irq}, 16'h0000);
    wr(ST, 16'h0004);
    rd(ST, 16'h0000);
    $display("pll test done");
  endtask
  task automatic t_xtal();
    @(posedge clk);
    crystal_stable_in <= 1'b1;
    settle();
    rd(ST, 16'h3000);
    cmp({15'h0000, crystal_event_irq}, 16'h0001);
    wr(ST, 16'hF000);
    rd(ST, 16'h1000);
    cmp({15'h0000, crystal_event_irq}, 16'h0000);
    @(posedge clk);
    crystal_stable_in <= 1'b0;
    settle();
    rd(ST, 16'h4000);
    cmp({15'h0000, crystal_event_irq}, 16'h0001);
    wr(ST, 16'h4000);
    rd(ST, 16'h0000);
    $display("crystal test done");
  endtask
  task automatic end_of_test();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    settle();
    arst_n <= 1'b1;
    settle();
    t_reset();
    t_gates();
    t_modes();
    t_pll();
    t_xtal();
    end_of_test();
  end
  initial
  begin
    #100000;
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: pcgs_top_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module pcgs_top_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire pcgs_pkg::pcgs_bus_s bus,
  input wire logic [15:0] rdata,
  input wire logic [1:0] power_mode,
  input wire logic core_sleeping,
  input wire logic crystal_stable_in,
  input wire logic serial_port_gated_clock,
  input wire logic second_twowire_gated_clock,
  input wire logic first_twowire_gated_clock,
  input wire logic second_shift_port_gated_clock,
  input wire logic first_shift_port_gated_clock,
  input wire logic bus_clocks_sleep,
  input wire logic crystal_event_irq
);
  // ----
  // Decoded accesses
  // ----
  wire logic gr = bus.rd && bus.addr == pcgs_pkg::PCGS_GATING_OFFSET;
  wire logic sr = bus.rd && bus.addr == pcgs_pkg::PCGS_STATUS_OFFSET;
  wire logic gw = bus.wr && bus.addr == pcgs_pkg::PCGS_GATING_OFFSET;
  wire logic any_clk = serial_port_gated_clock | second_twowire_gated_clock
    | first_twowire_gated_clock | second_shift_port_gated_clock
    | first_shift_port_gated_clock;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----
  // Properties
  // ----
  chk_gate_rsv_zero: assert property ($past(gr) |-> rdata[15:7] == 9'h000 && !rdata[2])
    else $error("gating reserved bits set");
  chk_keep_one: assert property ($past(gr) |-> rdata[6])
    else $error("gating bit 6 not one");
  chk_stat_rsv_zero: assert property ($past(sr) |-> !rdata[15] && rdata[11:3] == 9'h000)
    else $error("status reserved bits set");
  chk_deep_off: assert property (@(negedge clk) power_mode[1] [*8] |-> !any_clk)
    else $error("clock runs in deep mode");
  chk_gate_stop: assert property (@(negedge clk) gw && bus.wdata[5] ##1 !gw [*5]
    |-> !serial_port_gated_clock)
    else $error("serial clock not stopped");
  chk_xtal_good: assert property ($rose(crystal_stable_in) |-> ##[1:6] crystal_event_irq)
    else $error("no crystal good event");
  chk_xtal_lost: assert property ($fell(crystal_stable_in) |-> ##[1:6] crystal_event_irq)
    else $error("no crystal lost event");
  chk_bus_clocks_sleep: assert property ((power_mode == 2'h2 && core_sleeping) [*6]
    |-> bus_clocks_sleep)
    else $error("bus clocks not asleep");
  cover property ($past(sr) && rdata[14]);
  cover property (@(negedge clk) power_mode[1] [*8]);
  cover property (bus_clocks_sleep);
endmodule
bind pcgs_top pcgs_top_checker u_chk (.*);
`default_nettype wire
